// >>> src/gvl_logger.sv
/*
 * Gas value processing chain: calibration, trim, threshold check with
 * hysteresis, interval recording into an eight-sector circular memory.
 * Assumes the raw source and record memory run on clk_i; the memory
 * accepts one write or one sector erase per cycle without stalling.
 */
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module gvl_logger
    import gvl_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int SECTOR_LEN = SECTOR_RECS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic raw_valid_i,
    input wire logic [15:0] raw_i,
    output logic raw_ready_o,
    output logic [1:0] level_o,
    output logic entry_valid_o,
    output gvl_entry_t entry_o,
    output logic tx_request_o,
    output logic rec_wr_o,
    output logic [16:0] rec_addr_o,
    output gvl_rec_t rec_o,
    output logic erase_o,
    output logic [2:0] erase_sector_o
);
    typedef enum logic [4:0] {
        P_IDLE = 5'b00001,
        P_CAL = 5'b00010,
        P_TRIM = 5'b00100,
        P_CHECK = 5'b01000,
        P_REC = 5'b10000
    } gvl_pstate_t;
    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_ERASE = 3'b010,
        W_WRITE = 3'b100
    } gvl_wstate_t;

    // Saturating slope/offset stage in signed Q8.8 slope arithmetic.
    function automatic logic signed [31:0] scale(input logic signed [31:0] x,
            input logic signed [15:0] k, input logic signed [31:0] d);
        logic signed [49:0] p;
        p = (50'(x) * 50'(k)) >>> FRAC;
        p = p + 50'(d);
        if (p > 50'sh7fff_ffff) begin
            scale = 32'sh7fff_ffff;
        end else if (p < -50'sh8000_0000) begin
            scale = 32'sh8000_0000;
        end else begin
            scale = p[31:0];
        end
    endfunction

    // Hysteresis band as a percentage of the threshold's magnitude.
    function automatic logic signed [33:0] margin(input logic signed [31:0] t,
            input logic [6:0] h);
        logic [32:0] a;
        logic [39:0] m;
        a = t[31] ? 33'(-34'(t)) : 33'(t);
        m = (40'(a) * 40'(h)) / 40'd100;
        margin = 34'(m[32:0]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
            input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        merge = o;
    endfunction

    logic [1:0] ctrl_reg;
    logic signed [15:0] cal_k_reg, trim_k_reg;
    logic signed [31:0] cal_d_reg, trim_d_reg;
    logic signed [31:0] thr_reg [4];
    logic [6:0] hyst_reg;
    logic [15:0] interval_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    gvl_pstate_t pstate_reg;
    gvl_wstate_t wstate_reg;
    logic [15:0] raw_reg;
    logic signed [31:0] cal_reg, val_reg, last_reg;
    logic have_reg;
    logic [3:0] act_reg;
    logic entry_v_reg, tx_reg;
    gvl_entry_t entry_reg;
    logic [31:0] tick_reg;
    logic [15:0] sec_reg;
    logic due_reg;
    logic [16:0] wptr_reg, count_reg;
    logic rec_wr_reg, erase_reg;
    gvl_rec_t rec_reg;
    // Sector depth is a parameter so that a short run can fill and wrap the ring.
    // The address stays seventeen bits wide, which bounds the depth from above.
    localparam int TOTAL_LEN = SECTORS * SECTOR_LEN;

    wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic wr = req & wb_we_i;
    // Byte-lane merges are named wires, because a function result cannot be
    // part-selected; each narrow register then takes only its own low bits.
    wire logic [31:0] ctrl_m = merge({30'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
    wire logic [31:0] cal_k_m = merge({16'h0, cal_k_reg}, wb_dat_i, wb_sel_i);
    wire logic [31:0] trim_k_m = merge({16'h0, trim_k_reg}, wb_dat_i, wb_sel_i);
    wire logic [31:0] hyst_m = merge({25'h0, hyst_reg}, wb_dat_i, wb_sel_i);
    wire logic [31:0] interval_m = merge({16'h0, interval_reg}, wb_dat_i, wb_sel_i);
    wire logic trim_en = ctrl_reg[CTRL_TRIM_EN];
    wire logic standalone = ctrl_reg[CTRL_STANDALONE];
    wire logic [15:0] interval = standalone ? DEF_INTERVAL_S :
        (interval_reg == 16'h0000 ? 16'h0001 : interval_reg);
    wire logic signed [33:0] v34 = 34'(val_reg);
    wire logic [1:0] level = act_reg[3:2] != 2'b00 ? LVL_ALARM :
        (act_reg[1:0] != 2'b00 ? LVL_WARN : LVL_NONE);

    // Low thresholds trip at or below, high ones at or above.
    logic [3:0] hit, past;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i[0] == 1'b0) begin
                hit[i] = val_reg <= thr_reg[i];
                past[i] = v34 > 34'(thr_reg[i]) + margin(thr_reg[i], hyst_reg);
            end else begin
                hit[i] = val_reg >= thr_reg[i];
                past[i] = v34 < 34'(thr_reg[i]) - margin(thr_reg[i], hyst_reg);
            end
        end
    end
    wire logic [3:0] act_next = standalone ? 4'h0 :
        (hit | (act_reg & ~past));
    wire logic [3:0] set_m = act_next & ~act_reg;
    wire logic [3:0] clr_m = act_reg & ~act_next;
    wire logic full = count_reg == 17'(TOTAL_LEN);
    wire logic last_slot = wptr_reg == 17'(TOTAL_LEN - 1);
    wire logic tick_end = tick_reg == 32'(TICK_LEN - 1);
    wire logic sec_end = tick_end && (sec_reg >= interval - 16'h0001);
    wire logic take_rec = wstate_reg == W_IDLE && due_reg && have_reg;

    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            A_CTRL: rd_mux = {30'h0, ctrl_reg};
            A_CAL_SLOPE: rd_mux = {{16{cal_k_reg[15]}}, cal_k_reg};
            A_CAL_OFS: rd_mux = cal_d_reg;
            A_TRIM_SLOPE: rd_mux = {{16{trim_k_reg[15]}}, trim_k_reg};
            A_TRIM_OFS, A_ZERO_ADJ: rd_mux = trim_d_reg;
            A_WARN_LO: rd_mux = thr_reg[0];
            A_WARN_HI: rd_mux = thr_reg[1];
            A_ALM_LO: rd_mux = thr_reg[2];
            A_ALM_HI: rd_mux = thr_reg[3];
            A_HYST: rd_mux = {25'h0, hyst_reg};
            A_INTERVAL: rd_mux = {16'h0, interval};
            A_STATUS: rd_mux = {26'h0, act_reg, level};
            A_VALUE: rd_mux = val_reg;
            A_REC_COUNT: rd_mux = {15'h0, count_reg};
            A_CAL_VALUE: rd_mux = cal_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: ack rises the cycle after the request and drops after one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            rdata_reg <= req ? rd_mux : 32'h0000_0000;
        end
    end

    // Calibration and trim coefficients live in separate registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            cal_k_reg <= SLOPE_ONE;
            cal_d_reg <= 32'h0000_0000;
            trim_k_reg <= SLOPE_ONE;
            trim_d_reg <= 32'h0000_0000;
            thr_reg[0] <= THR_LO_RST;
            thr_reg[1] <= THR_HI_RST;
            thr_reg[2] <= THR_LO_RST;
            thr_reg[3] <= THR_HI_RST;
            hyst_reg <= HYST_RST;
            interval_reg <= DEF_INTERVAL_S;
        end else if (wr) begin
            case (wb_adr_i)
                A_CTRL: ctrl_reg <= ctrl_m[1:0];
                A_CAL_SLOPE: cal_k_reg <= cal_k_m[15:0];
                A_CAL_OFS: cal_d_reg <= merge(cal_d_reg, wb_dat_i, wb_sel_i);
                A_TRIM_SLOPE: trim_k_reg <= trim_k_m[15:0];
                A_TRIM_OFS, A_ZERO_ADJ: trim_d_reg <= merge(trim_d_reg, wb_dat_i, wb_sel_i);
                A_WARN_LO: thr_reg[0] <= merge(thr_reg[0], wb_dat_i, wb_sel_i);
                A_WARN_HI: thr_reg[1] <= merge(thr_reg[1], wb_dat_i, wb_sel_i);
                A_ALM_LO: thr_reg[2] <= merge(thr_reg[2], wb_dat_i, wb_sel_i);
                A_ALM_HI: thr_reg[3] <= merge(thr_reg[3], wb_dat_i, wb_sel_i);
                A_HYST: hyst_reg <= hyst_m[6:0];
                A_INTERVAL: begin
                    if (!standalone) begin
                        interval_reg <= interval_m[15:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // One stage per cycle keeps each reading's path in a fixed order.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pstate_reg <= P_IDLE;
            raw_reg <= 16'h0000;
            cal_reg <= 32'h0000_0000;
            val_reg <= 32'h0000_0000;
            last_reg <= 32'h0000_0000;
            have_reg <= 1'b0;
            act_reg <= 4'h0;
            entry_v_reg <= 1'b0;
            tx_reg <= 1'b0;
            entry_reg <= '0;
        end else begin
            entry_v_reg <= 1'b0;
            tx_reg <= 1'b0;
            case (pstate_reg)
                P_IDLE: begin
                    if (raw_valid_i) begin
                        raw_reg <= raw_i;
                        pstate_reg <= P_CAL;
                    end
                end
                P_CAL: begin
                    cal_reg <= scale(32'(raw_reg), cal_k_reg, cal_d_reg);
                    pstate_reg <= P_TRIM;
                end
                P_TRIM: begin
                    val_reg <= trim_en ? scale(cal_reg, trim_k_reg, trim_d_reg) : cal_reg;
                    pstate_reg <= P_CHECK;
                end
                P_CHECK: begin
                    act_reg <= act_next;
                    entry_v_reg <= (set_m | clr_m) != 4'h0;
                    tx_reg <= set_m != 4'h0;
                    entry_reg <= '{set_mask: set_m, clr_mask: clr_m, value: val_reg};
                    pstate_reg <= P_REC;
                end
                P_REC: begin
                    // Only the latest value is kept; the writer stores it at the boundary.
                    last_reg <= val_reg;
                    have_reg <= 1'b1;
                    pstate_reg <= P_IDLE;
                end
                default: pstate_reg <= P_IDLE;
            endcase
        end
    end

    // Record interval timer; a new boundary wins over the writer's clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_reg <= 32'h0000_0000;
            sec_reg <= 16'h0000;
            due_reg <= 1'b0;
        end else begin
            tick_reg <= tick_end ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
            if (sec_end) begin
                sec_reg <= 16'h0000;
            end else if (tick_end) begin
                sec_reg <= sec_reg + 16'h0001;
            end
            due_reg <= sec_end | (due_reg & ~take_rec);
        end
    end

    // Circular writer: a full buffer always wraps onto a sector start.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wstate_reg <= W_IDLE;
            wptr_reg <= 17'h00000;
            count_reg <= 17'h00000;
            rec_wr_reg <= 1'b0;
            erase_reg <= 1'b0;
            rec_reg <= '0;
        end else begin
            rec_wr_reg <= 1'b0;
            erase_reg <= 1'b0;
            // The pointer moves after the write pulse, so rec_addr_o names the slot
            // being written while rec_wr_o stands and erases find the oldest sector.
            if (rec_wr_reg) begin
                wptr_reg <= last_slot ? 17'h00000 : wptr_reg + 17'h00001;
            end
            case (wstate_reg)
                W_IDLE: begin
                    if (take_rec) begin
                        rec_reg <= '{level: level, value: last_reg};
                        wstate_reg <= full ? W_ERASE : W_WRITE;
                    end
                end
                W_ERASE: begin
                    erase_reg <= 1'b1;
                    count_reg <= count_reg - 17'(SECTOR_LEN);
                    wstate_reg <= W_WRITE;
                end
                W_WRITE: begin
                    rec_wr_reg <= 1'b1;
                    count_reg <= count_reg + 17'h00001;
                    wstate_reg <= W_IDLE;
                end
                default: wstate_reg <= W_IDLE;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign raw_ready_o = pstate_reg == P_IDLE;
    assign level_o = level;
    assign entry_valid_o = entry_v_reg;
    assign entry_o = entry_reg;
    assign tx_request_o = tx_reg;
    assign rec_wr_o = rec_wr_reg;
    assign rec_addr_o = wptr_reg;
    assign rec_o = rec_reg;
    assign erase_o = erase_reg;
    assign erase_sector_o = 3'(wptr_reg / 17'(SECTOR_LEN));

    stage_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        raw_valid_i && raw_ready_o |=> pstate_reg == P_CAL ##1 pstate_reg == P_TRIM
        ##1 pstate_reg == P_CHECK ##1 pstate_reg == P_REC)
        else $error("processing stages out of order");
    trim_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pstate_reg == P_TRIM && !trim_en |=> val_reg == $past(cal_reg))
        else $error("disabled trim changed the value");
    zero_adj_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == A_ZERO_ADJ |=> trim_k_reg == $past(trim_k_reg)
        && cal_k_reg == $past(cal_k_reg) && cal_d_reg == $past(cal_d_reg))
        else $error("zero adjust touched a slope or calibration");
    tx_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_request_o |-> entry_valid_o && entry_o.set_mask != 4'h0)
        else $error("transmission request without a raised event");
    standalone_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        standalone && pstate_reg == P_CHECK |=> act_reg == 4'h0 && !tx_request_o)
        else $error("threshold event in standalone mode");
    alarm_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        act_reg[3:2] != 2'b00 |-> level_o == LVL_ALARM)
        else $error("warning reported over an active alarm");
    erase_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_o |=> rec_wr_o && count_reg == 17'(TOTAL_LEN - SECTOR_LEN + 1))
        else $error("sector erase not followed by a write");
    count_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rec_wr_o |-> count_reg <= 17'(TOTAL_LEN) && rec_addr_o < 17'(TOTAL_LEN))
        else $error("record count or pointer out of range");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    // Ring placement: the pointer steps by one after each write and wraps at the end.
    pointer_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rec_wr_o |=> rec_addr_o == ($past(last_slot) ? 17'h00000 : $past(rec_addr_o) + 17'h00001))
        else $error("record pointer did not step by one");
    erase_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_o |-> rec_addr_o % 17'(SECTOR_LEN) == 17'h00000)
        else $error("sector erase away from a sector start");
    due_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        due_reg && !take_rec |=> due_reg)
        else $error("pending record dropped before it was stored");
endmodule
`default_nettype wire

// >>> src/gvl_pkg.sv
/*
 * Constants, register map and carrier types for the gas value alarm logger.
 * Assumes a single 10 MHz clock and a 32-bit classic Wishbone register bus.
 */
`default_nettype none
package gvl_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam logic [15:0] DEF_INTERVAL_S = 16'd60;
    localparam int FRAC = 8;
    localparam int SECTORS = 8;
    localparam int SECTOR_RECS = 10347;
    localparam int TOTAL_RECS = SECTORS * SECTOR_RECS;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CAL_SLOPE = 8'h04;
    localparam logic [7:0] A_CAL_OFS = 8'h08;
    localparam logic [7:0] A_TRIM_SLOPE = 8'h0c;
    localparam logic [7:0] A_TRIM_OFS = 8'h10;
    localparam logic [7:0] A_ZERO_ADJ = 8'h14;
    localparam logic [7:0] A_WARN_LO = 8'h18;
    localparam logic [7:0] A_WARN_HI = 8'h1c;
    localparam logic [7:0] A_ALM_LO = 8'h20;
    localparam logic [7:0] A_ALM_HI = 8'h24;
    localparam logic [7:0] A_HYST = 8'h28;
    localparam logic [7:0] A_INTERVAL = 8'h2c;
    localparam logic [7:0] A_STATUS = 8'h30;
    localparam logic [7:0] A_VALUE = 8'h34;
    localparam logic [7:0] A_REC_COUNT = 8'h38;
    localparam logic [7:0] A_CAL_VALUE = 8'h3c;
    localparam int CTRL_TRIM_EN = 0;
    localparam int CTRL_STANDALONE = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [15:0] SLOPE_ONE = 16'h0100;
    localparam logic [31:0] THR_LO_RST = 32'h8000_0000;
    localparam logic [31:0] THR_HI_RST = 32'h7fff_ffff;
    localparam logic [6:0] HYST_RST = 7'h00;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_WARN = 2'h1;
    localparam logic [1:0] LVL_ALARM = 2'h2;
    // Condition bit order: warn low, warn high, alarm low, alarm high.
    typedef struct packed {
        logic [3:0] set_mask;
        logic [3:0] clr_mask;
        logic signed [31:0] value;
    } gvl_entry_t;
    typedef struct packed {
        logic [1:0] level;
        logic signed [31:0] value;
    } gvl_rec_t;
endpackage
`default_nettype wire

// >>> testbench/gvl_logger_tb.sv
/*
 * Self-checking bench for the gas value logger: register access over classic Wishbone,
 * calibration and trim arithmetic, thresholds with hysteresis, interval recording.
 * Assumes the raw source model, a one-second tick of ten cycles and two-record sectors.
 */
`default_nettype none
module gvl_logger_tb import gvl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] RA [10] = '{A_CTRL, A_CAL_SLOPE, A_CAL_OFS, A_TRIM_SLOPE,
        A_TRIM_OFS, A_WARN_LO, A_ALM_HI, A_HYST, A_INTERVAL, 8'h40};
    localparam logic [31:0] RV [10] = '{32'h1, 32'h100, 32'h0, 32'h100, 32'h0,
        THR_LO_RST, THR_HI_RST, 32'h0, 32'h3c, 32'h0};
    localparam logic [31:0] TV [8] = '{32'h258, 32'h3e8, 32'h3b6, 32'h383, 32'h1c1,
        32'hffff_ff9c, 32'hffff_fe0c, 32'h0};
    localparam logic [1:0] TL [8] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
    localparam logic [1:0] DT [8] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
    localparam logic [1:0] DE [8] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
    localparam logic [3:0] TM [8] = '{4'h2, 4'h8, 4'h0, 4'h0, 4'h0, 4'h1, 4'h4, 4'h0};
    localparam logic [3:0] TC [8] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h2, 4'h0, 4'h0, 4'h5};
    localparam int SL = 2;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, wb_dat_o, rec_exp = 32'h0;
    logic wb_ack_o, raw_valid, raw_ready, entry_valid, tx_req, rec_wr, erase, src_fault;
    logic rec_chk = 1'b0, erased = 1'b0;
    logic [15:0] raw;
    logic [1:0] level;
    logic [3:0] last_set = 4'h0, last_clr = 4'h0;
    logic [16:0] rec_addr, exp_addr = 17'h0;
    logic [2:0] erase_sector;
    gvl_entry_t entry;
    gvl_rec_t rec;
    int err_count = 0, comparisons = 0, tx_cnt = 0, ent_cnt = 0, rec_cnt = 0, er_cnt = 0;
    gvl_logger #(.TICK_LEN(10), .SECTOR_LEN(SL)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .raw_valid_i(raw_valid), .raw_i(raw),
        .raw_ready_o(raw_ready), .level_o(level), .entry_valid_o(entry_valid),
        .entry_o(entry), .tx_request_o(tx_req), .rec_wr_o(rec_wr), .rec_addr_o(rec_addr),
        .rec_o(rec), .erase_o(erase), .erase_sector_o(erase_sector));
    gvl_raw_src src (.clk_i(clk_i), .ready_i(raw_ready), .valid_o(raw_valid), .raw_o(raw),
        .fault_o(src_fault));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic conclude;
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counters update by non-blocking assignment so the main sequence never races them.
    always @(posedge clk_i) begin
        if (!rst_i) begin
            if (tx_req === 1'b1) tx_cnt <= tx_cnt + 1;
            if (entry_valid === 1'b1) begin
                ent_cnt <= ent_cnt + 1;
                last_set <= entry.set_mask;
                last_clr <= entry.clr_mask;
            end
            if (erase === 1'b1) begin
                erased <= 1'b1;
                er_cnt <= er_cnt + 1;
                check(32'(erase_sector), 32'(exp_addr / SL));
            end
            if (rec_wr === 1'b1) begin
                check(32'(rec_addr), 32'(exp_addr));
                check(32'(erased), 32'(rec_cnt >= 8 * SL && exp_addr % SL == 0));
                erased <= 1'b0;
                exp_addr <= exp_addr == 17'(8 * SL - 1) ? 17'h0 : exp_addr + 17'h1;
                rec_cnt <= rec_cnt + 1;
                if (rec_chk) begin
                    check(rec.value, rec_exp);
                    check(32'(rec.level), 32'(LVL_NONE));
                end
            end
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            conclude();
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // Eight cycles cover the five-cycle pipeline walk with margin.
    task automatic feed(input logic [15:0] r);
        src.send(r);
        repeat (8) @(posedge clk_i);
        if (src_fault === 1'b1) begin
            err_count++;
            conclude();
        end
    endtask
    // With a raw value of zero and trim off, the measured value equals the calibration offset.
    task automatic set_val(input logic [31:0] v);
        wr(A_CAL_OFS, v);
        feed(16'h0);
    endtask
    initial begin
        int i, t0, e0, r0, ncyc, nrec, n;
        time ts;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 10; i++) rd_chk(RA[i], RV[i]);
        wr(A_CTRL, 32'h0);
        wr(A_CAL_SLOPE, 32'h200);
        wr(A_CAL_OFS, 32'h5);
        feed(16'h64);
        rd_chk(A_CAL_VALUE, 32'hcd);
        rd_chk(A_VALUE, 32'hcd);
        wr(A_CTRL, 32'h1);
        wr(A_TRIM_SLOPE, 32'h200);
        wr(A_TRIM_OFS, 32'h3);
        feed(16'h64);
        rd_chk(A_VALUE, 32'h19d);
        wr(A_ZERO_ADJ, 32'h7);
        rd_chk(A_TRIM_OFS, 32'h7);
        rd_chk(A_TRIM_SLOPE, 32'h200);
        rd_chk(A_CAL_SLOPE, 32'h200);
        rd_chk(A_CAL_OFS, 32'h5);
        feed(16'h64);
        rd_chk(A_VALUE, 32'h1a1);
        wr(A_CTRL, 32'h0);
        wr(A_CAL_SLOPE, 32'h100);
        wr(A_WARN_HI, 32'h1f4);
        wr(A_ALM_HI, 32'h3e8);
        wr(A_WARN_LO, 32'hffff_ff9c);
        wr(A_ALM_LO, 32'hffff_fe0c);
        wr(A_HYST, 32'ha);
        for (i = 0; i < 8; i++) begin
            t0 = tx_cnt;
            e0 = ent_cnt;
            set_val(TV[i]);
            check(32'(level), 32'(TL[i]));
            check(32'(tx_cnt - t0), 32'(DT[i]));
            check(32'(ent_cnt - e0), 32'(DE[i]));
            if (DE[i] != 2'h0) check(32'(last_set), 32'(TM[i]));
            if (DE[i] != 2'h0) check(32'(last_clr), 32'(TC[i]));
        end
        wr(A_CTRL, 32'h2);
        wr(A_INTERVAL, 32'h5);
        rd_chk(A_INTERVAL, 32'h3c);
        t0 = tx_cnt;
        set_val(32'h7d0);
        check(32'(level), 32'(LVL_NONE));
        check(32'(tx_cnt - t0), 32'h0);
        wr(A_CTRL, 32'h0);
        rd_chk(A_INTERVAL, 32'h3c);
        wr(A_INTERVAL, 32'h2);
        set_val(32'h4d);
        rec_exp = 32'h4d;
        n = 0;
        while (rec_wr !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n < 1000), 32'h1);
        @(posedge clk_i);
        rec_chk <= 1'b1;
        r0 = rec_cnt;
        ts = $time;
        // Readings arrive every ten cycles, twice as fast as one record per twenty.
        for (i = 0; i < 40; i++) feed(16'h0);
        ncyc = int'(($time - ts) / 100);
        nrec = rec_cnt - r0;
        check(32'(nrec >= ncyc / 20 - 1 && nrec <= ncyc / 20 + 1), 32'h1);
        check(32'(er_cnt > 0), 32'h1);
        // The bench reads out as the scheduling party once recording stops; the held
        // count must still cover at least seven full sectors.
        wr(A_INTERVAL, 32'hffff);
        repeat (6) @(posedge clk_i);
        n = rec_cnt;
        rd_chk(A_REC_COUNT, 32'(n <= 8 * SL ? n : 7 * SL + 1 + (n - 1) % SL));
        conclude();
    end
    initial begin
        #9_000_000;
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire

// >>> testbench/gvl_raw_src.sv
/*
 * Behavioural model of the raw-value acquisition front end that feeds the logger.
 * Assumes the logger takes a reading at the rising edge where valid and ready are both high.
 */
`default_nettype none
module gvl_raw_src (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [15:0] raw_o,
    output logic fault_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        valid_o = 1'b0;
        raw_o = 16'hffff;
        fault_o = 1'b0;
    end
    // The reading is held until taken, since the logger applies back-pressure while busy.
    task automatic send(input logic [15:0] v);
        int n;
        @(posedge clk_i);
        valid_o <= 1'b1;
        raw_o <= v;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ready_i !== 1'b1 && n < 40);
        fault_o <= fault_o | (n >= 40);
        valid_o <= 1'b0;
        // A released bus shows the inverse, so a stale value cannot pass for fresh data.
        raw_o <= ~v;
    endtask
endmodule
`default_nettype wire
